// *** scsp_pkg.sv ***
// scsp_pkg: constants, register map and encodings of the system clock source and prescaler
// assumes: APB slave with 32-bit data, clock pclk at 250 MHz
package scsp_pkg;
   // register byte offsets
   localparam logic [11:0] SCSP_OFF_TRIM = 12'h000;
   localparam logic [11:0] SCSP_OFF_DIV = 12'h004;
   localparam logic [11:0] SCSP_OFF_STATUS = 12'h008;
   // field positions
   localparam int SCSP_UNLOCK_BIT = 7;
   localparam int SCSP_TRIM_MSB = 6;
   // encodings
   localparam logic [3:0] SCSP_SRC_RC = 4'h2;
   localparam logic [3:0] SCSP_SRC_EXT = 4'h0;
   localparam logic [3:0] SCSP_DIV_RST_PLAIN = 4'h0;
   localparam logic [3:0] SCSP_DIV_RST_BY8 = 4'h3;
   localparam logic [3:0] SCSP_DIV_MAX = 4'h8;
   localparam logic [2:0] SCSP_UNLOCK_CYCLES = 3'h4;
   localparam logic [2:0] SCSP_WAKE_CYCLES = 3'h6;
   // start-up delays in microseconds and as counts at the bus clock rate
   localparam int SCSP_CLK_MHZ = 250;
   localparam int SCSP_DLY_SHORT_US = 4100;
   localparam int SCSP_DLY_LONG_US = 65000;
   localparam int SCSP_DLY_SHORT_CYC = SCSP_DLY_SHORT_US * SCSP_CLK_MHZ;
   localparam int SCSP_DLY_LONG_CYC = SCSP_DLY_LONG_US * SCSP_CLK_MHZ;
   localparam logic [1:0] SCSP_SUT_NONE = 2'h0;
   localparam logic [1:0] SCSP_SUT_SHORT = 2'h1;
   localparam logic [1:0] SCSP_SUT_LONG = 2'h2;
   typedef enum logic [1:0] {
      SCSP_ST_DELAY = 2'b00,
      SCSP_ST_RUN = 2'b01,
      SCSP_ST_FAULT = 2'b10
   } scsp_state_e;
endpackage

// *** scsp_top.sv ***
// scsp_top: clock source selection, rc trim, start-up delay, prescaler and clock output
// assumes: fuses and calibration byte are static straps; ext clock and timer inputs are pins
module scsp_top #(
   parameter int DLY_SHORT = scsp_pkg::SCSP_DLY_SHORT_CYC,
   parameter int DLY_LONG = scsp_pkg::SCSP_DLY_LONG_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [3:0] clock_source_select_fuses,
   input wire logic [1:0] startup_time_fuses,
   input wire logic divide_by_eight_fuse,
   input wire logic clock_output_fuse,
   input wire logic [7:0] calibration_byte,
   input wire logic external_clock_input,
   input wire logic rc_osc_clock,
   input wire logic watchdog_osc_clock,
   input wire logic timer_osc_input,
   input wire logic timer_sync_mode,
   input wire logic portb0_normal_out,
   input wire logic portb0_normal_oe,
   output logic [6:0] rc_trim_value,
   output logic sys_clock_en,
   output logic async_timer_clock,
   output logic wdt_clock,
   output logic irq_block,
   output logic core_reset_n,
   output logic portb0_out,
   output logic portb0_oe
);
   import scsp_pkg::*;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [3:0] sync1;
   logic [3:0] sync2;
   // no reset: the pins keep being sampled while presetn is low
   always_ff @(posedge pclk) begin
      if (clk_en) begin
         sync1 <= {external_clock_input, rc_osc_clock, watchdog_osc_clock, timer_osc_input};
         sync2 <= sync1;
      end
   end
   logic ext_s;
   logic rc_s;
   logic wdt_s;
   logic tosc_s;
   assign ext_s = sync2[3];
   assign rc_s = sync2[2];
   assign wdt_s = sync2[1];
   assign tosc_s = sync2[0];

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   logic wr_acc;
   logic rd_acc;
   logic hit_trim;
   logic hit_div;
   logic hit_stat;
   assign wr_acc = psel && penable && pwrite && pstrb[0];
   assign rd_acc = psel && penable && !pwrite;
   assign hit_trim = (paddr == SCSP_OFF_TRIM);
   assign hit_div = (paddr == SCSP_OFF_DIV);
   assign hit_stat = (paddr == SCSP_OFF_STATUS);

   function automatic logic code_ok(input logic [3:0] c);
      code_ok = (c <= SCSP_DIV_MAX);
   endfunction

   // ----------------------------------------------------------------
   // trim register
   // ----------------------------------------------------------------
   logic trim_loaded;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rc_trim_value <= 7'h00;
         trim_loaded <= 1'b0;
      end else if (clk_en) begin
         if (!trim_loaded) begin
            rc_trim_value <= calibration_byte[SCSP_TRIM_MSB:0];
            trim_loaded <= 1'b1;
         end else if (wr_acc && hit_trim) begin
            rc_trim_value <= pwdata[SCSP_TRIM_MSB:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // prescaler unlock and select
   // ----------------------------------------------------------------
   logic unlock;
   logic [2:0] unlock_cnt;
   logic [3:0] div_sel;
   logic div_loaded;
   logic unlock_req;
   logic sel_write;
   assign unlock_req = wr_acc && hit_div && pwdata[SCSP_UNLOCK_BIT] && (pwdata[6:0] == 7'h00);
   assign sel_write = wr_acc && hit_div && !pwdata[SCSP_UNLOCK_BIT];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         unlock <= 1'b0;
         unlock_cnt <= 3'h0;
      end else if (clk_en) begin
         if (unlock_req) begin
            unlock <= 1'b1;
            unlock_cnt <= SCSP_UNLOCK_CYCLES;
         end else if (unlock && (sel_write || unlock_cnt == 3'h1)) begin
            unlock <= 1'b0;
            unlock_cnt <= 3'h0;
         end else if (unlock) begin
            unlock_cnt <= unlock_cnt - 3'h1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_sel <= SCSP_DIV_RST_PLAIN;
         div_loaded <= 1'b0;
      end else if (clk_en) begin
         if (!div_loaded) begin
            div_sel <= divide_by_eight_fuse ? SCSP_DIV_RST_BY8 : SCSP_DIV_RST_PLAIN;
            div_loaded <= 1'b1;
         end else if (unlock && sel_write) begin
            div_sel <= pwdata[3:0];
         end
      end
   end

   // reserved codes keep the last valid factor
   logic [3:0] div_active;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_active <= SCSP_DIV_RST_PLAIN;
      end else if (clk_en && code_ok(div_sel)) begin
         div_active <= div_sel;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_block <= 1'b0;
      end else if (clk_en) begin
         irq_block <= unlock_req || (unlock && !sel_write && unlock_cnt != 3'h1);
      end
   end

   // ----------------------------------------------------------------
   // source selection and edge detection
   // ----------------------------------------------------------------
   logic src_level;
   logic src_prev;
   logic src_rise;
   logic src_valid;
   always_comb begin
      src_valid = 1'b1;
      case (clock_source_select_fuses)
         SCSP_SRC_RC: src_level = rc_s;
         SCSP_SRC_EXT: src_level = ext_s;
         default: begin
            src_level = 1'b0;
            src_valid = 1'b0;
         end
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_prev <= 1'b0;
      end else if (clk_en) begin
         src_prev <= src_level;
      end
   end
   assign src_rise = src_level && !src_prev;

   // ----------------------------------------------------------------
   // start-up delay, counted on the bus clock
   // ----------------------------------------------------------------
   scsp_state_e state;
   logic [31:0] dly_cnt;
   logic [31:0] dly_target;
   always_comb begin
      case (startup_time_fuses)
         SCSP_SUT_NONE: dly_target = 32'h0;
         SCSP_SUT_SHORT: dly_target = DLY_SHORT;
         SCSP_SUT_LONG: dly_target = DLY_LONG;
         default: dly_target = 32'h0;
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= SCSP_ST_DELAY;
         dly_cnt <= 32'h0;
         core_reset_n <= 1'b0;
      end else if (clk_en) begin
         case (state)
            SCSP_ST_DELAY: begin
               if (startup_time_fuses == 2'b11 || !src_valid) begin
                  state <= SCSP_ST_FAULT;
               end else if (dly_cnt >= dly_target) begin
                  state <= SCSP_ST_RUN;
                  core_reset_n <= 1'b1;
               end else begin
                  dly_cnt <= dly_cnt + 32'h1;
               end
            end
            SCSP_ST_RUN: core_reset_n <= 1'b1;
            SCSP_ST_FAULT: core_reset_n <= 1'b0;
            default: state <= SCSP_ST_DELAY;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // prescaler: counts source edges, divides by two to the code
   // ----------------------------------------------------------------
   logic [7:0] pre_cnt;
   logic [7:0] pre_mask;
   logic div_tick;
   logic div_clk;
   assign pre_mask = 8'((9'h1 << div_active) - 9'h1);
   assign div_tick = src_rise && ((pre_cnt & pre_mask) == pre_mask);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_cnt <= 8'h00;
         div_clk <= 1'b0;
         sys_clock_en <= 1'b0;
      end else if (clk_en) begin
         if (src_rise) begin
            pre_cnt <= div_tick ? 8'h00 : pre_cnt + 8'h01;
         end
         if (div_active == 4'h0) begin
            div_clk <= src_level;
         end else if (src_rise && (pre_cnt & (pre_mask >> 1)) == (pre_mask >> 1)) begin
            div_clk <= !div_clk;
         end
         sys_clock_en <= div_tick;
      end
   end

   // ----------------------------------------------------------------
   // derived clocks and port b bit 0
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         async_timer_clock <= 1'b0;
         wdt_clock <= 1'b0;
      end else if (clk_en) begin
         async_timer_clock <= timer_sync_mode ? div_clk : tosc_s;
         wdt_clock <= wdt_s;
      end
   end

   // no reset: the clock output override must hold during reset too
   always_ff @(posedge pclk) begin
      if (clk_en) begin
         if (clock_output_fuse) begin
            portb0_out <= div_clk;
            portb0_oe <= 1'b1;
         end else begin
            portb0_out <= portb0_normal_out;
            portb0_oe <= portb0_normal_oe;
         end
      end
   end

   // ----------------------------------------------------------------
   // apb read data
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else if (clk_en) begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !(hit_trim || hit_div || hit_stat);
         prdata <= 32'h0;
         if (psel && !penable && !pwrite) begin
            if (hit_trim) prdata <= {24'h0, 1'b0, rc_trim_value};
            if (hit_div) prdata <= {24'h0, unlock, 3'h0, div_sel};
            if (hit_stat) prdata <= {24'h0, 3'h0, SCSP_WAKE_CYCLES, state};
         end
      end
   end
   logic unused_rd;
   assign unused_rd = rd_acc;
endmodule

// *** scsp_monitor.sv ***
// scsp_monitor: port-level assertions for scsp_top
// assumes: clk_en held high and pstrb all ones while checked
module scsp_monitor
   import scsp_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic [1:0] startup_time_fuses,
   input wire logic clock_output_fuse,
   input wire logic [7:0] calibration_byte,
   input wire logic [6:0] rc_trim_value,
   input wire logic irq_block,
   input wire logic core_reset_n,
   input wire logic portb0_oe
);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic div_wr = psel && penable && pready && pwrite && paddr == SCSP_OFF_DIV;
   property p_ready_after_setup;
      psel && !penable |=> pready;
   endproperty
   a_ready_after_setup: assert property (p_ready_after_setup) else $error("no ready");
   property p_trim_msb;
      pready && !pwrite && paddr == SCSP_OFF_TRIM |-> !prdata[7];
   endproperty
   a_trim_msb: assert property (p_trim_msb) else $error("trim bit 7 set");
   property p_trim_reset;
      $rose(presetn) |-> ##[1:2] rc_trim_value == calibration_byte[6:0];
   endproperty
   a_trim_reset: assert property (p_trim_reset) else $error("trim not loaded");
   property p_unlock_opens;
      div_wr && pwdata[7:0] == 8'h80 |-> ##[1:2] irq_block;
   endproperty
   a_unlock_opens: assert property (p_unlock_opens) else $error("no irq block");
   property p_window_bound;
      $rose(irq_block) |-> ##[1:5] !irq_block;
   endproperty
   a_window_bound: assert property (p_window_bound) else $error("window too long");
   property p_div_closes;
      div_wr && !pwdata[7] && irq_block |-> ##[1:2] !irq_block;
   endproperty
   a_div_closes: assert property (p_div_closes) else $error("window stays open");
   property p_clkout;
      clock_output_fuse |-> ##2 portb0_oe;
   endproperty
   a_clkout: assert property (p_clkout) else $error("clock output off");
   property p_sut_reserved;
      startup_time_fuses == 2'h3 |-> !core_reset_n;
   endproperty
   a_sut_reserved: assert property (p_sut_reserved) else $error("core left reset");
endmodule
bind scsp_top scsp_monitor scsp_monitor_i (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .pready, .startup_time_fuses, .clock_output_fuse,
   .calibration_byte, .rc_trim_value, .irq_block, .core_reset_n, .portb0_oe);

// *** scsp_partner.sv ***
// scsp_partner: steady oscillators and external clock on the pin side
// assumes: rates well below half the bus clock rate
module scsp_partner (
   output logic external_clock_input,
   output logic rc_osc_clock,
   output logic watchdog_osc_clock,
   output logic timer_osc_input
);
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------
   // sources
   // ----------------------------------------
   initial begin
      external_clock_input = 1'b0;
      rc_osc_clock = 1'b0;
      watchdog_osc_clock = 1'b0;
      timer_osc_input = 1'b0;
   end
   // fixed period, never jumps in frequency
   always #40 external_clock_input = ~external_clock_input;
   always #20 rc_osc_clock = ~rc_osc_clock;
   always #50 watchdog_osc_clock = ~watchdog_osc_clock;
   always #100 timer_osc_input = ~timer_osc_input;
endmodule

// *** scsp_top_bench.sv ***
// scsp_top_bench: register and clock-rate tests of scsp_top over apb
// assumes: scsp_partner supplies rc at 40 ns and external clock at 80 ns
module scsp_top_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import scsp_pkg::*;
   logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb, clock_source_select_fuses;
   logic [1:0] startup_time_fuses;
   logic divide_by_eight_fuse, clock_output_fuse, timer_sync_mode;
   logic [7:0] calibration_byte;
   logic external_clock_input, rc_osc_clock, watchdog_osc_clock, timer_osc_input;
   logic portb0_normal_out, portb0_normal_oe, sys_clock_en, async_timer_clock, wdt_clock;
   logic irq_block, core_reset_n, portb0_out, portb0_oe;
   logic [6:0] rc_trim_value;
   int fail_count = 0;
   int checked = 0;
   int n, m, w, a;
   scsp_top #(.DLY_SHORT(20), .DLY_LONG(40)) scsp_top_i (.*);
   scsp_partner scsp_partner_i (.*);
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      check(pready, 1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rst(input logic [3:0] s, input logic [1:0] t, input logic d8, input logic co);
      @(posedge pclk);
      clock_source_select_fuses <= s;
      startup_time_fuses <= t;
      divide_by_eight_fuse <= d8;
      clock_output_fuse <= co;
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
   endtask
   // counts divided clock pulses and rises of clock output, watchdog and timer clocks
   task cnt(output int c, output int p, output int wr, output int ar);
      logic q, qw, qa;
      c = 0;
      p = 0;
      wr = 0;
      ar = 0;
      repeat (300) @(posedge pclk);
      q = portb0_out;
      qw = wdt_clock;
      qa = async_timer_clock;
      repeat (800) begin
         @(posedge pclk);
         c += sys_clock_en;
         p += portb0_out && !q;
         wr += wdt_clock && !qw;
         ar += async_timer_clock && !qa;
         q = portb0_out;
         qw = wdt_clock;
         qa = async_timer_clock;
      end
   endtask
   task give_verdict;
      if (fail_count == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // ----------------------------------------
   // stimulus
   // ----------------------------------------
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   initial begin
      #200000;
      fail_count++;
      give_verdict;
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, timer_sync_mode} = '0;
      {portb0_normal_out, portb0_normal_oe, clock_source_select_fuses} = '0;
      {startup_time_fuses, divide_by_eight_fuse, clock_output_fuse} = '0;
      clk_en = 1'b1;
      pstrb = 4'hF;
      calibration_byte = 8'hD5;
      rst(SCSP_SRC_RC, SCSP_SUT_NONE, 1'b1, 1'b1);
      apb(0, SCSP_OFF_TRIM, 0);
      check(rd, 32'h55);
      check(rc_trim_value, 7'h55);
      apb(0, SCSP_OFF_DIV, 0);
      check(rd, 32'h3);
      apb(0, SCSP_OFF_STATUS, 0);
      check(rd[4:0], {SCSP_WAKE_CYCLES, SCSP_ST_RUN});
      apb(1, SCSP_OFF_TRIM, 32'hFF); // no memory write in flight
      apb(0, SCSP_OFF_TRIM, 0);
      check(rd, 32'h7F);
      check(rc_trim_value, 7'h7F);
      apb(0, 12'h00C, 0);
      check(err, 1'b1);
      apb(1, SCSP_OFF_DIV, 32'h5);
      apb(1, SCSP_OFF_DIV, 32'h81);
      apb(1, SCSP_OFF_DIV, 32'h5);
      apb(0, SCSP_OFF_DIV, 0);
      check(rd, 32'h3);
      apb(1, SCSP_OFF_DIV, 32'h80);
      repeat (2) @(posedge pclk);
      check(irq_block, 1'b1);
      repeat (6) @(posedge pclk);
      check(irq_block, 1'b0);
      apb(1, SCSP_OFF_DIV, 32'h2);
      apb(0, SCSP_OFF_DIV, 0);
      check(rd, 32'h3);
      for (int i = 8; i >= 0; i--) begin
         apb(1, SCSP_OFF_DIV, 32'h80); // nothing between the two steps
         apb(1, SCSP_OFF_DIV, i);
         apb(0, SCSP_OFF_DIV, 0);
         check(rd, i);
         if (i < 4) begin
            cnt(n, m, w, a);
            check(n >= (80 >> i) - 1 && n <= (80 >> i) + 1, 1);
            check(m >= (80 >> i) - 1 && m <= (80 >> i) + 1, 1);
         end
      end
      check(w >= 31 && w <= 33, 1);
      check(a >= 15 && a <= 17, 1);
      apb(1, SCSP_OFF_DIV, 32'h80);
      apb(1, SCSP_OFF_DIV, 32'h9);
      cnt(n, m, w, a);
      check(n >= 79 && n <= 81, 1);
      portb0_normal_oe <= 1'b1;
      portb0_normal_out <= 1'b1;
      rst(SCSP_SRC_EXT, SCSP_SUT_SHORT, 1'b0, 1'b0);
      n = 0;
      while (core_reset_n !== 1'b1 && n < 1000) begin
         @(posedge pclk);
         n++;
      end
      check(n >= 20 && n < 1000, 1);
      check(portb0_oe, 1'b1);
      apb(0, SCSP_OFF_DIV, 0);
      check(rd, 32'h0);
      cnt(n, m, w, a);
      check(n >= 39 && n <= 41, 1);
      rst(SCSP_SRC_RC, 2'h3, 1'b0, 1'b1);
      repeat (50) @(posedge pclk);
      check(core_reset_n, 1'b0);
      check(portb0_oe, 1'b1);
      give_verdict;
   end
endmodule
